// >>> mover_pkg.sv
`default_nettype none
package mover_pkg;
   // channel layout: even index receives, odd index transmits
   localparam int NumPeriph  = 4;
   localparam int NumChan    = 2 * NumPeriph;
   localparam int ChanIdxW   = 3;
   localparam int PtrWidth   = 32;
   localparam int CntWidth   = 16;
   localparam int DataWidth  = 32;
   localparam logic [PtrWidth-1:0] PtrReset = 32'h0000_0000;
   localparam logic [CntWidth-1:0] CntReset = 16'h0000;
   // item size codes: bytes moved per item is 1 << code
   localparam logic [1:0] SizeByte = 2'h0;
   localparam logic [1:0] SizeHalf = 2'h1;
   localparam logic [1:0] SizeWord = 2'h2;
   localparam int DirBit = 0;
   typedef enum logic [1:0] {IdleSt, BusySt, RecoverSt} mover_state_type;
endpackage
`default_nettype wire

// >>> mover_channel.sv
`default_nettype none
module mover_channel #(
   parameter int PtrW = mover_pkg::PtrWidth,
   parameter int CntW = mover_pkg::CntWidth
) (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            nrst,
   // register writes from the owning peripheral
   input  wire logic            ptrWr,
   input  wire logic            cntWr,
   input  wire logic [PtrW-1:0] wrData,
   // item completion
   input  wire logic            advance,
   input  wire logic [PtrW-1:0] stepBytes,
   // state
   output var  logic [PtrW-1:0] ptr_q,
   output var  logic [CntW-1:0] cnt_q,
   output var  logic            endPulse_q
);
   logic [PtrW-1:0] ptr_d;
   logic [CntW-1:0] cnt_d;
   logic            endPulse_d;
   wire             live = (cnt_q != '0);

   // software load wins over a completing item in the same cycle
   assign ptr_d = ptrWr ? wrData
                : (advance && live) ? ptr_q + stepBytes : ptr_q;
   assign cnt_d = cntWr ? wrData[CntW-1:0]
                : (advance && live) ? cnt_q - 1'b1 : cnt_q;
   assign endPulse_d = !cntWr && advance && (cnt_q == 1);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ptr_q      <= mover_pkg::PtrReset;
         cnt_q      <= mover_pkg::CntReset;
         endPulse_q <= 1'b0;
      end
      else
      begin
         ptr_q      <= ptr_d;
         cnt_q      <= cnt_d;
         endPulse_q <= endPulse_d;
      end
   end

   //==========================================================
   // checks
   chk_count_step: assert property (@(posedge clock)
      disable iff (!nrst)
      advance && live && !cntWr |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("count did not step down");
   chk_ptr_step: assert property (@(posedge clock)
      disable iff (!nrst)
      advance && live && !ptrWr |=> ptr_q == $past(ptr_q) + $past(stepBytes))
      else $error("pointer did not advance by item size");
   chk_end_pulse: assert property (@(posedge clock)
      disable iff (!nrst)
      endPulse_q |-> cnt_q == '0 && $past(cnt_q) == 1)
      else $error("end pulse without last item");
endmodule
`default_nettype wire

// >>> peripheral_data_mover.sv
//Behaviour
//- eight channels: one receive and one transmit per serial peripheral
//- items move between peripherals and memory with no processor work
//- each channel holds a 32-bit pointer and 16-bit count
//- owning peripheral gets an end pulse when the last item moves
//- up to 65535 contiguous items of 1 << code bytes each move from one start address
//- pointer and count are written through the owning peripheral's space
`default_nettype none
module peripheral_data_mover #(
   parameter int NumPeriph = mover_pkg::NumPeriph
) (
   // clock and reset
   input  wire logic                                 clock,
   input  wire logic                                 nrst,
   // register writes decoded inside each owning peripheral
   input  wire logic [2*NumPeriph-1:0]               ptrWr,
   input  wire logic [2*NumPeriph-1:0]               cntWr,
   input  wire logic [mover_pkg::PtrWidth-1:0]       regWdata,
   // register readback towards the owning peripheral
   output var  logic [2*NumPeriph-1:0][mover_pkg::PtrWidth-1:0] ptrValue,
   output var  logic [2*NumPeriph-1:0][mover_pkg::CntWidth-1:0] cntValue,
   output var  logic [2*NumPeriph-1:0]               endOfXfer,
   // peripheral data paths
   input  wire logic [2*NumPeriph-1:0]               xferReq,
   input  wire logic [NumPeriph-1:0][1:0]            itemCode,
   input  wire logic [NumPeriph-1:0][mover_pkg::DataWidth-1:0] rxData,
   output var  logic [2*NumPeriph-1:0]               xferAck,
   output var  logic [mover_pkg::DataWidth-1:0]      txData,
   // system memory bus
   output var  logic                                 memReq,
   output var  logic                                 memWrite,
   output var  logic [mover_pkg::PtrWidth-1:0]       memAddr,
   output var  logic [mover_pkg::DataWidth-1:0]      memWdata,
   output var  logic [1:0]                           memSize,
   input  wire logic                                 memAck,
   input  wire logic [mover_pkg::DataWidth-1:0]      memRdata
);
   localparam int NumChan = 2 * NumPeriph;
   localparam int IdxW    = mover_pkg::ChanIdxW;

   mover_pkg::mover_state_type state_q;
   mover_pkg::mover_state_type state_d;

   logic [NumChan-1:0][mover_pkg::PtrWidth-1:0] ptr;
   logic [NumChan-1:0][mover_pkg::CntWidth-1:0] cnt;
   logic [NumChan-1:0]                 eligible;
   logic [NumChan-1:0]                 advance;
   logic [IdxW-1:0]                    pick;
   logic                               anyPick;
   logic [IdxW-1:0]                    grant_q;
   logic [NumChan-1:0]                 ack_q;
   logic [mover_pkg::DataWidth-1:0]    txData_q;
   logic                               memReq_q;
   logic                               memWrite_q;
   logic [mover_pkg::PtrWidth-1:0]     memAddr_q;
   logic [mover_pkg::DataWidth-1:0]    memWdata_q;
   logic [1:0]                         memSize_q;

   //==========================================================
   // channels
   genvar gi;
   generate
      for (gi = 0; gi < NumChan; gi++)
      begin : chan
         wire [1:0] code = itemCode[gi/2];
         wire [mover_pkg::PtrWidth-1:0] step =
            mover_pkg::PtrWidth'(1) << code;
         assign eligible[gi] = xferReq[gi] && (cnt[gi] != '0);
         assign advance[gi]  = (state_q == mover_pkg::BusySt) && memAck &&
                               (grant_q == IdxW'(gi));
         // pointer and count live behind the peripheral's own decode
         mover_channel #(
            .PtrW(mover_pkg::PtrWidth),
            .CntW(mover_pkg::CntWidth)
         ) u_chan (
            .clock     (clock),
            .nrst      (nrst),
            .ptrWr     (ptrWr[gi]),
            .cntWr     (cntWr[gi]),
            .wrData    (regWdata),
            .advance   (advance[gi]),
            .stepBytes (step),
            .ptr_q     (ptr[gi]),
            .cnt_q     (cnt[gi]),
            .endPulse_q(endOfXfer[gi])
         );
      end
   endgenerate

   //==========================================================
   // fixed priority: lowest channel index first
   always_comb
   begin
      pick    = '0;
      anyPick = 1'b0;
      for (int i = NumChan - 1; i >= 0; i--)
      begin
         if (eligible[i])
         begin
            pick    = IdxW'(i);
            anyPick = 1'b1;
         end
      end
   end

   wire            pickRx   = (pick[mover_pkg::DirBit] == 1'b0);
   wire [IdxW-2:0] pickPer  = pick[IdxW-1:1];
   wire            grantTx  = grant_q[mover_pkg::DirBit];
   wire            finishing = (state_q == mover_pkg::BusySt) && memAck;

   //==========================================================
   // sequencer
   // recover state gives the peripheral one edge to drop its request
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         mover_pkg::IdleSt:
            if (anyPick)
               state_d = mover_pkg::BusySt;
         mover_pkg::BusySt:
            if (memAck)
               state_d = mover_pkg::RecoverSt;
         mover_pkg::RecoverSt:
            state_d = mover_pkg::IdleSt;
         default:
            state_d = mover_pkg::IdleSt;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q    <= mover_pkg::IdleSt;
         grant_q    <= '0;
         memReq_q   <= 1'b0;
         memWrite_q <= 1'b0;
         memAddr_q  <= '0;
         memWdata_q <= '0;
         memSize_q  <= mover_pkg::SizeByte;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == mover_pkg::IdleSt && anyPick)
         begin
            grant_q    <= pick;
            memReq_q   <= 1'b1;
            memWrite_q <= pickRx;
            memAddr_q  <= ptr[pick];
            memWdata_q <= rxData[pickPer];
            memSize_q  <= itemCode[pickPer];
         end
         else if (finishing)
            memReq_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_q    <= '0;
         txData_q <= '0;
      end
      else
      begin
         ack_q <= advance;
         if (finishing && grantTx)
            txData_q <= memRdata;
      end
   end

   assign ptrValue = ptr;
   assign cntValue = cnt;
   assign xferAck  = ack_q;
   assign txData   = txData_q;
   assign memReq   = memReq_q;
   assign memWrite = memWrite_q;
   assign memAddr  = memAddr_q;
   assign memWdata = memWdata_q;
   assign memSize  = memSize_q;

   //==========================================================
   // checks
   chk_start_live: assert property (@(posedge clock)
      disable iff (!nrst)
      $rose(memReq_q) |-> $past(cnt[pick]) != '0 && $past(xferReq[pick]))
      else $error("access started for idle channel");
   chk_dir_map: assert property (@(posedge clock)
      disable iff (!nrst)
      memReq_q |-> memWrite_q == !grant_q[0])
      else $error("direction does not match channel");
   chk_ack_follow: assert property (@(posedge clock)
      disable iff (!nrst)
      memReq_q && memAck |=> xferAck[grant_q] && $onehot(xferAck) && !memReq)
      else $error("completion not acknowledged to peripheral");
   chk_addr_ptr: assert property (@(posedge clock)
      disable iff (!nrst)
      $rose(memReq_q) |-> memAddr_q == $past(ptr[pick]))
      else $error("address not taken from pointer");

   //==========================================================
   // access and handshake checks
   chk_req_hold: assert property (@(posedge clock)
      disable iff (!nrst)
      memReq_q && !memAck |=> memReq_q && $stable(memAddr_q) &&
         $stable(memWrite_q) && $stable(memSize_q))
      else $error("access fields moved before completion");
   chk_wdata_rx: assert property (@(posedge clock)
      disable iff (!nrst)
      $rose(memReq_q) && memWrite_q |->
         memWdata_q == $past(rxData[pick[IdxW-1:1]]))
      else $error("write data not taken from receiver");
   chk_tx_data: assert property (@(posedge clock)
      disable iff (!nrst)
      memReq_q && memAck && grant_q[mover_pkg::DirBit] |=>
         txData == $past(memRdata))
      else $error("read data not handed to transmitter");
   chk_size_code: assert property (@(posedge clock)
      disable iff (!nrst)
      $rose(memReq_q) |-> memSize_q == $past(itemCode[pick[IdxW-1:1]]))
      else $error("access size differs from item size");
   chk_end_ack: assert property (@(posedge clock)
      disable iff (!nrst)
      |endOfXfer |-> (endOfXfer & ~xferAck) == '0)
      else $error("end pulse without matching completion");
endmodule
`default_nettype wire

// >>> mover_mem_model.sv
`default_nettype none
module mover_mem_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // memory bus
   input  wire logic        memReq,
   input  wire logic [31:0] memAddr,
   input  wire logic [3:0]  lat,
   output var  logic        memAck,
   output var  logic [31:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   // read data is only good with ack; otherwise a moving pattern
   assign memRdata = memAck ? ~memAddr : memAddr ^ {28'h0, wait_q};
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         memAck <= 1'b0;
         wait_q <= 4'h0;
      end
      else
      begin
         memAck <= memReq && !memAck && wait_q == lat;
         wait_q <= (memReq && !memAck && wait_q != lat) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// >>> peripheral_data_mover_tb.sv
`default_nettype none
module peripheral_data_mover_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, nrst = 1'b0, memReq, memWrite, memAck, capWr, capEnd;
   logic [7:0] ptrWr, cntWr, xferReq, endOfXfer, xferAck;
   logic [31:0] regWdata, txData, memAddr, memWdata, memRdata;
   logic [31:0] capAddr, capData;
   logic [1:0]  capSize;
   logic [7:0][31:0] ptrValue;
   logic [7:0][15:0] cntValue;
   logic [3:0][1:0] itemCode;
   logic [3:0][31:0] rxData;
   logic [1:0] memSize;
   logic [3:0] lat;
   int mismatches = 0, checks_done = 0, cycles = 0;
   always #25 clock = ~clock;
   peripheral_data_mover dut (.clock(clock), .nrst(nrst), .ptrWr(ptrWr),
      .cntWr(cntWr), .regWdata(regWdata), .ptrValue(ptrValue),
      .cntValue(cntValue), .endOfXfer(endOfXfer), .xferReq(xferReq),
      .itemCode(itemCode), .rxData(rxData), .xferAck(xferAck),
      .txData(txData), .memReq(memReq), .memWrite(memWrite),
      .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize),
      .memAck(memAck), .memRdata(memRdata));
   mover_mem_model mem (.clock(clock), .nrst(nrst), .memReq(memReq),
      .memAddr(memAddr), .lat(lat), .memAck(memAck), .memRdata(memRdata));
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // generous: the whole run needs well under a thousand cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         close_out();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic load(input int ch, input logic [31:0] p,
                       input logic [15:0] c);
      @(posedge clock);
      ptrWr[ch] <= 1'b1;
      regWdata <= p;
      @(posedge clock);
      ptrWr[ch] <= 1'b0;
      cntWr[ch] <= 1'b1;
      regWdata <= {16'h0, c};
      @(posedge clock);
      cntWr[ch] <= 1'b0;
   endtask
   // request held until the edge that sees the ack, then dropped
   task automatic item(input int ch, input logic [7:0] more);
      int n;
      n = 0;
      @(posedge clock);
      xferReq <= xferReq | more | (8'h01 << ch);
      do
      begin
         @(negedge clock);
         n++;
         if (memReq && memAck)
         begin
            capAddr = memAddr;
            capWr = memWrite;
            capData = memWdata;
            capSize = memSize;
         end
      end
      while (xferAck[ch] !== 1'b1 && n < 40);
      // a missing acknowledge must not pass silently
      check("ack", {31'h0, xferAck[ch]}, 32'h1);
      capEnd = endOfXfer[ch];
      @(posedge clock);
      xferReq[ch] <= 1'b0;
   endtask
   task automatic sc_reset();
      @(negedge clock);
      check("ptr0", ptrValue[0], 32'h0);
      check("cnt7", {16'h0, cntValue[7]}, 32'h0);
      check("req", {31'h0, memReq}, 32'h0);
   endtask
   task automatic sc_receive();
      load(0, 32'h0000_1000, 16'h0002);
      item(0, 8'h00);
      check("rxAddr", capAddr, 32'h0000_1000);
      check("rxWr", {31'h0, capWr}, 32'h1);
      check("rxData", capData, 32'hA5A5_0000);
      check("rxPtr", ptrValue[0], 32'h0000_1004);
      check("rxCnt", {16'h0, cntValue[0]}, 32'h1);
      check("rxEnd", {31'h0, capEnd}, 32'h0);
      item(0, 8'h00);
      check("rxPtr2", ptrValue[0], 32'h0000_1008);
      check("rxEnd2", {31'h0, capEnd}, 32'h1);
   endtask
   task automatic sc_refuse();
      logic seen;
      seen = 1'b0;
      @(posedge clock);
      xferReq[0] <= 1'b1;
      repeat (10)
      begin
         @(negedge clock);
         seen = seen | memReq | xferAck[0];
      end
      @(posedge clock);
      xferReq[0] <= 1'b0;
      check("refused", {31'h0, seen}, 32'h0);
   endtask
   task automatic sc_sizes();
      for (int k = 0; k < 3; k++)
      begin
         load(2, 32'h0000_2000, 16'h0001);
         itemCode[1] <= 2'(k);
         item(2, 8'h00);
         check("step", ptrValue[2], 32'h0000_2000 + (32'h1 << k));
         check("end", {31'h0, capEnd}, 32'h1);
         check("size", {30'h0, capSize}, 32'(k));
      end
   endtask
   task automatic sc_transmit();
      lat <= 4'h3;
      itemCode[3] <= mover_pkg::SizeHalf;
      load(7, 32'hFFFF_FFFE, 16'h0001);
      item(7, 8'h00);
      check("txWr", {31'h0, capWr}, 32'h0);
      check("txData", txData, 32'h0000_0001);
      check("txWrap", ptrValue[7], 32'h0);
      check("txEnd", {31'h0, capEnd}, 32'h1);
      check("txSize", {30'h0, capSize}, {30'h0, mover_pkg::SizeHalf});
      lat <= 4'h0;
   endtask
   // loaded pointer and count must clear on a reset in mid-run
   task automatic sc_midreset();
      load(6, 32'h0000_5000, 16'h0003);
      check("ptrLd", ptrValue[6], 32'h0000_5000);
      nrst <= 1'b0;
      @(negedge clock);
      check("ptrRst", ptrValue[6], 32'h0);
      check("cntRst", {16'h0, cntValue[6]}, 32'h0);
      @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      check("cntRel", {16'h0, cntValue[6]}, 32'h0);
      check("reqRel", {31'h0, memReq}, 32'h0);
   endtask
   task automatic sc_priority();
      load(1, 32'h0000_3000, 16'h0001);
      load(4, 32'h0000_4000, 16'h0001);
      item(1, 8'h10);
      check("first", capAddr, 32'h0000_3000);
      item(4, 8'h00);
      check("second", capAddr, 32'h0000_4000);
      load(5, 32'hFFFF_FFFF, 16'hFFFF);
      @(negedge clock);
      check("ptrW", ptrValue[5], 32'hFFFF_FFFF);
      check("cntW", {16'h0, cntValue[5]}, 32'h0000_FFFF);
   endtask
   initial
   begin
      {ptrWr, cntWr, xferReq, regWdata, lat} = '0;
      itemCode = {4{mover_pkg::SizeWord}};
      rxData = {32'hA5A5_0003, 32'hA5A5_0002, 32'hA5A5_0001, 32'hA5A5_0000};
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      sc_reset();
      sc_receive();
      sc_refuse();
      sc_sizes();
      sc_transmit();
      sc_midreset();
      sc_priority();
      close_out();
   end
endmodule
`default_nettype wire
